// ---- core/rtc_lock_pkg.sv ----
// Purpose: shared constants and types for the clock status and write-lock block
// Assumes: 32-bit AXI4-Lite register bus, byte addresses
// Notes: offsets other than status and lock are local choices
package rtc_lock_pkg;
  localparam logic [7:0] seconds_off = 8'h00;
  localparam logic [7:0] prescaler_off = 8'h04;
  localparam logic [7:0] alarm_off = 8'h08;
  localparam logic [7:0] compensation_off = 8'h0c;
  localparam logic [7:0] control_off = 8'h10;
  localparam logic [7:0] clock_status_off = 8'h14;
  localparam logic [7:0] register_write_locks_off = 8'h18;
  localparam logic [7:0] irq_status_off = 8'h1c;
  localparam logic [7:0] irq_mask_off = 8'h20;
  // status bit positions
  localparam int time_invalid_pos = 0;
  localparam int overflow_pos = 1;
  localparam int alarm_pos = 2;
  localparam int counter_enable_pos = 4;
  // lock bit positions
  localparam int compensation_lock_pos = 3;
  localparam int controlreg_lock_pos = 4;
  localparam int statusreg_lock_pos = 5;
  localparam int lockreg_lock_pos = 6;
  // control bit positions
  localparam int software_reset_pos = 0;
  localparam int update_mode_pos = 3;
  localparam logic [15:0] prescaler_reset = 16'h0000;
  localparam logic [31:0] seconds_reset = 32'h0000_0000;
  localparam logic [3:0] locks_reset = 4'hf;
  localparam logic [31:0] lock_fixed_ones = 32'h0000_0087;
  // prescaler bit whose falling edge advances seconds
  localparam int seconds_tick_pos = 14;
  // oscillator rate and system clock rate
  localparam int osc_hz = 32768;
  localparam int clk_hz = 125000000;
  localparam logic [1:0] resp_okay = 2'b00;
  localparam logic [1:0] resp_slverr = 2'b10;

  typedef struct packed {
    logic counter_enable_bit;
    logic alarm_flag;
    logic overflow_flag;
    logic time_invalid_flag;
  } status_s;

  typedef struct packed {
    logic lockreg_lock_bit;
    logic statusreg_lock_bit;
    logic controlreg_lock_bit;
    logic compensation_lock_bit;
  } locks_s;
endpackage

// ---- core/rtc_lock.sv ----
// Purpose: clock status flags, counters gating and register write locks
// Assumes: one clock aclk, synchronous active-low reset aresetn
// Notes: the 32.768 kHz tick is a fractional divider enable on aclk
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps

// How it works
// [RULE1] enable clear: counters writable, held still
// [RULE2] enable set: counter writes ignored, counters advance
// [RULE3] alarm flag sets when alarm equals seconds and seconds advances
// [RULE4] any alarm register write clears the alarm flag
// [RULE5] overflow flag sets when enabled seconds wraps past maximum
// [RULE6] overflow set: counters stop and read zero
// [RULE7] time-invalid flag is one after power-on or software reset
// [RULE8] time-invalid set: counters stop and read zero
// [RULE9] seconds write with enable clear clears overflow and invalid flags
// [RULE10] status bits 31..5 and 3 read zero
// [RULE11] lock register writes ignored while its lock bit is zero
// [RULE12] status register writes ignored while its lock bit is zero
// [RULE13] control writes ignored when locked; relocks only at power-on
// [RULE14] compensation writes ignored while its lock bit is zero
// [RULE15] other lock bits return to one only by either reset
// [RULE16] lock bit 7 and 2..0 read one, 31..8 read zero
// [RULE17] software reset bit reinitialises all but itself and the control lock
// [RULE18] update mode lets enable be written despite locked status
// [RULE19] software can only clear lock bits, never set them
module rtc_lock (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq,
  output logic [7:0] compensation_value,
  output logic [31:0] control_value
);
  // fractional accumulator step for the oscillator tick
  localparam logic [31:0] tick_step = 32'(rtc_lock_pkg::osc_hz);
  localparam logic [31:0] tick_limit = 32'(rtc_lock_pkg::clk_hz);

  logic [31:0] seconds_reg;
  logic [15:0] prescaler_reg;
  logic [31:0] alarm_reg;
  logic [7:0] compensation_reg;
  logic [31:0] control_reg;
  rtc_lock_pkg::status_s status_reg;
  rtc_lock_pkg::locks_s locks_reg;
  logic controlreg_lock_reg;
  logic [2:0] irq_status_reg;
  logic [2:0] irq_mask_reg;
  logic [31:0] tick_acc_reg;
  logic tick;
  logic soft_rst;
  logic running;
  logic [15:0] prescaler_next;
  logic seconds_step;
  logic alarm_hit;
  logic wrap_hit;

  // write channel capture
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] waddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic wr_go;
  logic [31:0] wmask;

  // software reset is control bit 0; it reinitialises the registers but that bit and the control lock
  assign soft_rst = control_reg[rtc_lock_pkg::software_reset_pos];

  // divider: one-cycle enable at the oscillator rate
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_acc_reg <= 32'h0000_0000;
    end else if (tick_acc_reg + tick_step >= tick_limit) begin
      tick_acc_reg <= tick_acc_reg + tick_step - tick_limit;
    end else begin
      tick_acc_reg <= tick_acc_reg + tick_step;
    end
  end
  assign tick = (tick_acc_reg + tick_step >= tick_limit);

  // counting only with enable set and both stop flags clear
  assign running = status_reg.counter_enable_bit && !status_reg.overflow_flag &&
                   !status_reg.time_invalid_flag; // [RULE2] [RULE6] [RULE8]
  assign prescaler_next = prescaler_reg + 16'h0001;
  // seconds advance on the falling edge of the tick bit
  assign seconds_step = running && tick && prescaler_reg[rtc_lock_pkg::seconds_tick_pos] &&
                        !prescaler_next[rtc_lock_pkg::seconds_tick_pos];
  assign alarm_hit = seconds_step && (alarm_reg == seconds_reg); // [RULE3]
  assign wrap_hit = seconds_step && (seconds_reg == 32'hffff_ffff); // [RULE5]

  // write handshake: address and data accepted in either order
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
  assign wr_go = aw_held_reg && w_held_reg && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      waddr_reg <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg <= 1'b1;
      waddr_reg <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg <= 1'b1;
      wdata_reg <= s_axi_wdata;
      wstrb_reg <= s_axi_wstrb;
    end else if (wr_go) begin
      w_held_reg <= 1'b0;
    end
  end

  // byte strobes widened to a bit mask
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_strb
      assign wmask[gi*8 +: 8] = {8{wstrb_reg[gi]}};
    end
  endgenerate

  // write response, unmapped offsets answer slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= rtc_lock_pkg::resp_okay;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (waddr_reg[7:2] > rtc_lock_pkg::irq_mask_off[7:2]) ?
                     rtc_lock_pkg::resp_slverr : rtc_lock_pkg::resp_okay;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  function automatic logic hit(input logic [7:0] off);
    hit = wr_go && (waddr_reg[7:2] == off[7:2]);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] m,
                                        input logic [31:0] d);
    merge = (old & ~m) | (d & m);
  endfunction

  // control register, software reset bit survives its own reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control_reg <= 32'h0000_0000;
    end else if (hit(rtc_lock_pkg::control_off) && controlreg_lock_reg) begin // [RULE13]
      control_reg <= merge(control_reg, wmask, wdata_reg);
    end else if (soft_rst) begin
      control_reg <= control_reg & (32'h1 << rtc_lock_pkg::software_reset_pos); // [RULE17]
    end
  end

  // control lock only returns with power-on reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      controlreg_lock_reg <= 1'b1;
    end else if (hit(rtc_lock_pkg::register_write_locks_off) && locks_reg.lockreg_lock_bit &&
                 wmask[rtc_lock_pkg::controlreg_lock_pos] &&
                 !wdata_reg[rtc_lock_pkg::controlreg_lock_pos]) begin // [RULE11] [RULE19]
      controlreg_lock_reg <= 1'b0; // [RULE13]
    end
  end

  // remaining lock bits: clear only, relock on either reset
  always_ff @(posedge aclk) begin
    if (!aresetn || soft_rst) begin
      locks_reg <= rtc_lock_pkg::locks_reset; // [RULE15]
    end else if (hit(rtc_lock_pkg::register_write_locks_off) &&
                 locks_reg.lockreg_lock_bit) begin // [RULE11]
      locks_reg.lockreg_lock_bit <= locks_reg.lockreg_lock_bit &
                                    (wdata_reg[rtc_lock_pkg::lockreg_lock_pos] |
                                     !wmask[rtc_lock_pkg::lockreg_lock_pos]); // [RULE19]
      locks_reg.statusreg_lock_bit <= locks_reg.statusreg_lock_bit &
                                      (wdata_reg[rtc_lock_pkg::statusreg_lock_pos] |
                                       !wmask[rtc_lock_pkg::statusreg_lock_pos]); // [RULE19]
      locks_reg.compensation_lock_bit <= locks_reg.compensation_lock_bit &
                                         (wdata_reg[rtc_lock_pkg::compensation_lock_pos] |
                                          !wmask[rtc_lock_pkg::compensation_lock_pos]);
    end
  end

  // compensation and alarm registers
  always_ff @(posedge aclk) begin
    if (!aresetn || soft_rst) begin
      compensation_reg <= 8'h00;
    end else if (hit(rtc_lock_pkg::compensation_off) && locks_reg.compensation_lock_bit &&
                 wmask[0]) begin // [RULE14]
      compensation_reg <= wdata_reg[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || soft_rst) begin
      alarm_reg <= 32'h0000_0000;
    end else if (hit(rtc_lock_pkg::alarm_off)) begin
      alarm_reg <= merge(alarm_reg, wmask, wdata_reg);
    end
  end

  // time counters: written only with enable clear, else advance
  always_ff @(posedge aclk) begin
    if (!aresetn || soft_rst) begin
      prescaler_reg <= rtc_lock_pkg::prescaler_reset;
    end else if (hit(rtc_lock_pkg::prescaler_off) && !status_reg.counter_enable_bit) begin
      // only the low half of the bus word maps onto the prescaler
      prescaler_reg <= (prescaler_reg & ~wmask[15:0]) |
                       (wdata_reg[15:0] & wmask[15:0]); // [RULE1]
    end else if (running && tick) begin
      prescaler_reg <= prescaler_next; // [RULE2]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || soft_rst) begin
      seconds_reg <= rtc_lock_pkg::seconds_reset;
    end else if (hit(rtc_lock_pkg::seconds_off) && !status_reg.counter_enable_bit) begin
      seconds_reg <= merge(seconds_reg, wmask, wdata_reg); // [RULE1]
    end else if (seconds_step) begin
      seconds_reg <= seconds_reg + 32'h0000_0001; // [RULE2]
    end
  end

  // status flags; hardware set beats software clear
  always_ff @(posedge aclk) begin
    if (!aresetn || soft_rst) begin
      status_reg <= 4'b0001; // [RULE7]
    end else begin
      // only the enable is software writable; flags move by hardware, seconds loads and alarm writes
      if ((hit(rtc_lock_pkg::clock_status_off) && wmask[rtc_lock_pkg::counter_enable_pos]) &&
          (locks_reg.statusreg_lock_bit ||
           (control_reg[rtc_lock_pkg::update_mode_pos] &&
            (status_reg.overflow_flag || status_reg.time_invalid_flag ||
             !status_reg.counter_enable_bit)))) begin // [RULE12] [RULE18]
        status_reg.counter_enable_bit <= wdata_reg[rtc_lock_pkg::counter_enable_pos];
      end
      if (alarm_hit) begin
        status_reg.alarm_flag <= 1'b1; // [RULE3]
      end else if (hit(rtc_lock_pkg::alarm_off)) begin
        status_reg.alarm_flag <= 1'b0; // [RULE4]
      end
      if (wrap_hit) begin
        status_reg.overflow_flag <= 1'b1; // [RULE5]
      end else if (hit(rtc_lock_pkg::seconds_off) && !status_reg.counter_enable_bit) begin
        status_reg.overflow_flag <= 1'b0; // [RULE9]
      end
      if (hit(rtc_lock_pkg::seconds_off) && !status_reg.counter_enable_bit) begin
        status_reg.time_invalid_flag <= 1'b0; // [RULE9]
      end
    end
  end

  // sticky interrupt status {alarm, overflow, invalid}, write one to clear
  always_ff @(posedge aclk) begin
    if (!aresetn || soft_rst) begin
      irq_status_reg <= 3'b001;
    end else begin
      irq_status_reg <= (irq_status_reg & ~((hit(rtc_lock_pkg::irq_status_off)) ?
                         (wdata_reg[2:0] & wmask[2:0]) : 3'b000)) |
                        {alarm_hit, wrap_hit, 1'b0};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || soft_rst) begin
      irq_mask_reg <= 3'b000;
    end else if (hit(rtc_lock_pkg::irq_mask_off)) begin
      // one enable per sticky bit, a zero byte strobe keeps them
      irq_mask_reg <= (irq_mask_reg & ~wmask[2:0]) | (wdata_reg[2:0] & wmask[2:0]);
    end
  end

  // level interrupt and register copies for the rest of the chip
  assign irq = |(irq_status_reg & irq_mask_reg);
  assign compensation_value = compensation_reg;
  assign control_value = control_reg;

  // read channel: one read at a time, data from flip-flops
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= rtc_lock_pkg::resp_okay;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= rtc_lock_pkg::resp_okay;
      unique case (s_axi_araddr[7:2])
        rtc_lock_pkg::seconds_off[7:2]:
          s_axi_rdata <= (status_reg.overflow_flag || status_reg.time_invalid_flag) ?
                         32'h0000_0000 : seconds_reg; // [RULE6] [RULE8]
        rtc_lock_pkg::prescaler_off[7:2]:
          s_axi_rdata <= (status_reg.overflow_flag || status_reg.time_invalid_flag) ?
                         32'h0000_0000 : {16'h0000, prescaler_reg}; // [RULE6] [RULE8]
        rtc_lock_pkg::alarm_off[7:2]: s_axi_rdata <= alarm_reg;
        rtc_lock_pkg::compensation_off[7:2]: s_axi_rdata <= {24'h000000, compensation_reg};
        rtc_lock_pkg::control_off[7:2]: s_axi_rdata <= control_reg;
        rtc_lock_pkg::clock_status_off[7:2]:
          s_axi_rdata <= {27'h0, status_reg.counter_enable_bit, 1'b0, status_reg.alarm_flag,
                          status_reg.overflow_flag, status_reg.time_invalid_flag}; // [RULE10]
        rtc_lock_pkg::register_write_locks_off[7:2]:
          s_axi_rdata <= rtc_lock_pkg::lock_fixed_ones |
                         {25'h0, locks_reg.lockreg_lock_bit, locks_reg.statusreg_lock_bit,
                          controlreg_lock_reg, locks_reg.compensation_lock_bit,
                          3'b000}; // [RULE16]
        rtc_lock_pkg::irq_status_off[7:2]: s_axi_rdata <= {29'h0, irq_status_reg};
        rtc_lock_pkg::irq_mask_off[7:2]: s_axi_rdata <= {29'h0, irq_mask_reg};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= rtc_lock_pkg::resp_slverr;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// ---- sim/rtc_lock_sva.sv ----
// Purpose: port-level checks of the clock status and lock block
// Assumes: one clock domain, synchronous active-low reset
// Notes: register state is seen only through bus answers and copies
`timescale 1ns/1ps
module rtc_lock_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq,
  input wire logic [7:0] compensation_value,
  input wire logic [31:0] control_value
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // answers stand until the master takes them
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped early");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped early");
  property p_r_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_lat: assert property (p_r_lat) else $error("read answer late");
  property p_b_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_b_lat: assert property (p_b_lat) else $error("write answer late");
  // one transfer of each kind at a time
  property p_ar_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("read taken while answering");
  property p_aw_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_aw_block: assert property (p_aw_block) else $error("write taken while answering");
  // copies only move with a completing write
  // a software reset also clears them, all but control bit 0, one cycle after its bit was seen set
  property p_comp_write;
    !$stable(compensation_value) |->
      $rose(s_axi_bvalid) || (compensation_value == 8'h00 && $past(control_value[0]));
  endproperty
  a_comp_write: assert property (p_comp_write) else $error("compensation changed");
  property p_ctrl_write;
    !$stable(control_value) |->
      $rose(s_axi_bvalid) || (control_value == 32'h1 && $past(control_value[0]));
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control moved alone");
  property p_reset_idle;
    $rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !irq;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("not idle after reset");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_irq: cover property ($rose(irq));
endmodule

bind rtc_lock rtc_lock_sva u_sva (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .irq, .compensation_value, .control_value);

// ---- sim/rtc_lock_tb.sv ----
// Purpose: self-checking bench for status flags and write locks
// Assumes: bench is the bus master, waits of 5000 cycles span one tick
// Notes: prescaler preload 0x7fff makes the next tick advance seconds
`timescale 1ns/1ps
module rtc_lock_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, compensation_value;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, control_value, rd_data, s, v;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp, wr_resp;
  int bad_count = 0;
  int num_checks = 0;
  int seed = 82547;

  always #4 aclk = ~aclk;
  rtc_lock u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq,
    .compensation_value, .control_value);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // handshakes sampled at the falling edge, where nothing moves
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic aw_hs, w_hs, b_hs;
    n = 0;
    b_hs = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b_hs && n < 100) begin
      @(negedge aclk);
      aw_hs = s_axi_awvalid && s_axi_awready;
      w_hs = s_axi_wvalid && s_axi_wready;
      b_hs = s_axi_bvalid;
      wr_resp = s_axi_bresp;
      n++;
      @(posedge aclk);
      if (aw_hs) s_axi_awvalid <= 1'b0;
      if (w_hs) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    chk(32'(b_hs), 32'h1);
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    logic ar_hs, r_hs;
    n = 0;
    r_hs = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!r_hs && n < 100) begin
      @(negedge aclk);
      ar_hs = s_axi_arvalid && s_axi_arready;
      r_hs = s_axi_rvalid;
      rd_data = s_axi_rdata;
      rd_resp = s_axi_rresp;
      n++;
      @(posedge aclk);
      if (ar_hs) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    chk(32'(r_hs), 32'h1);
  endtask

  // expected lock readback from {lock reg, status, control, compensation}
  function automatic logic [31:0] lock_word(input logic [3:0] l);
    lock_word = rtc_lock_pkg::lock_fixed_ones | {25'h0, l, 3'h0};
  endfunction

  // expected status readback from {enable, alarm, overflow, invalid}
  function automatic logic [31:0] status_word(input logic [3:0] f);
    status_word = {27'h0, f[3], 1'b0, f[2:0]};
  endfunction

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rd_data, e);
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // hang guard, well past the two tick waits
  initial begin
    repeat (60000) @(posedge aclk);
    bad_count++;
    finish_test();
  end

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rc(rtc_lock_pkg::clock_status_off, status_word(4'h1));
    rc(rtc_lock_pkg::register_write_locks_off, lock_word(4'hf));
    rc(rtc_lock_pkg::seconds_off, 32'h0);
    // a stopped prescaler takes a load but reads zero while time is invalid
    wr(rtc_lock_pkg::prescaler_off, 32'h1234);
    rc(rtc_lock_pkg::prescaler_off, 32'h0);
    rc(rtc_lock_pkg::irq_status_off, 32'h1);
    wr(rtc_lock_pkg::irq_mask_off, 32'h1);
    chk(32'(wr_resp), 32'(rtc_lock_pkg::resp_okay));
    chk(32'(irq), 32'h1);
    wr(rtc_lock_pkg::irq_status_off, 32'h1);
    chk(32'(irq), 32'h0);
    rc(rtc_lock_pkg::irq_status_off, 32'h0);
    // random loads while stopped read back unchanged
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      wr(rtc_lock_pkg::prescaler_off, v);
      wr(rtc_lock_pkg::seconds_off, ~v);
      rc(rtc_lock_pkg::prescaler_off, {16'h0, v[15:0]});
      rc(rtc_lock_pkg::seconds_off, ~v);
    end
    rc(rtc_lock_pkg::clock_status_off, status_word(4'h0));
    s = $random(seed);
    s[31] = 1'b0;
    wr(rtc_lock_pkg::prescaler_off, 32'h7fff);
    wr(rtc_lock_pkg::seconds_off, s);
    wr(rtc_lock_pkg::alarm_off, s);
    wr(rtc_lock_pkg::clock_status_off, 32'h10);
    wr(rtc_lock_pkg::seconds_off, 32'h0);
    repeat (5000) @(posedge aclk);
    rc(rtc_lock_pkg::seconds_off, s + 32'h1);
    rc(rtc_lock_pkg::clock_status_off, status_word(4'hc));
    wr(rtc_lock_pkg::alarm_off, s);
    rc(rtc_lock_pkg::clock_status_off, status_word(4'h8));
    // wrap from the top value
    wr(rtc_lock_pkg::clock_status_off, 32'h0);
    wr(rtc_lock_pkg::prescaler_off, 32'h7fff);
    wr(rtc_lock_pkg::seconds_off, 32'hffff_ffff);
    wr(rtc_lock_pkg::clock_status_off, 32'h10);
    repeat (5000) @(posedge aclk);
    rc(rtc_lock_pkg::clock_status_off, status_word(4'ha));
    rc(rtc_lock_pkg::seconds_off, 32'h0);
    rc(rtc_lock_pkg::prescaler_off, 32'h0);
    rc(rtc_lock_pkg::irq_status_off, 32'h6);
    wr(rtc_lock_pkg::irq_mask_off, 32'h2);
    chk(32'(irq), 32'h1);
    wr(rtc_lock_pkg::irq_mask_off, 32'h0);
    chk(32'(irq), 32'h0);
    // locks: clear one at a time, ones never relock
    v = $random(seed);
    wr(rtc_lock_pkg::compensation_off, {24'h0, v[7:0]});
    wr(rtc_lock_pkg::register_write_locks_off, 32'hf7);
    wr(rtc_lock_pkg::compensation_off, {24'h0, ~v[7:0]});
    rc(rtc_lock_pkg::compensation_off, {24'h0, v[7:0]});
    chk(32'(compensation_value), {24'h0, v[7:0]});
    wr(rtc_lock_pkg::register_write_locks_off, 32'hff);
    rc(rtc_lock_pkg::register_write_locks_off, lock_word(4'he));
    wr(rtc_lock_pkg::register_write_locks_off, 32'hd7);
    wr(rtc_lock_pkg::clock_status_off, 32'h0);
    rc(rtc_lock_pkg::clock_status_off, status_word(4'ha));
    wr(rtc_lock_pkg::control_off, 32'h8);
    wr(rtc_lock_pkg::clock_status_off, 32'h0);
    rc(rtc_lock_pkg::clock_status_off, status_word(4'h2));
    // a seconds load with the enable clear lifts the overflow stop
    wr(rtc_lock_pkg::seconds_off, 32'h5);
    rc(rtc_lock_pkg::clock_status_off, status_word(4'h0));
    rc(rtc_lock_pkg::seconds_off, 32'h5);
    wr(rtc_lock_pkg::register_write_locks_off, 32'h97);
    wr(rtc_lock_pkg::register_write_locks_off, 32'h87);
    rc(rtc_lock_pkg::register_write_locks_off, lock_word(4'h2));
    wr(rtc_lock_pkg::control_off, 32'h9);
    rc(rtc_lock_pkg::clock_status_off, status_word(4'h1));
    rc(rtc_lock_pkg::register_write_locks_off, lock_word(4'hf));
    rc(rtc_lock_pkg::compensation_off, 32'h0);
    chk(control_value, 32'h1);
    // a control lock cleared under software reset stays cleared
    wr(rtc_lock_pkg::register_write_locks_off, 32'hef);
    rc(rtc_lock_pkg::register_write_locks_off, lock_word(4'hd));
    wr(rtc_lock_pkg::control_off, 32'h8);
    chk(control_value, 32'h1);
    wr(8'h24, 32'h1);
    chk(32'(wr_resp), 32'(rtc_lock_pkg::resp_slverr));
    rd(8'h24);
    chk(32'(rd_resp), 32'(rtc_lock_pkg::resp_slverr));
    chk(rd_data, 32'h0);
    finish_test();
  end
endmodule
